// *** rtl/agc_pkg.sv ***
// constants shared by the gain stepper: register map, fields, reset values, timing
package agc_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] GAIN_OFS   = 8'h04;
  localparam logic [7:0] LEVEL_OFS  = 8'h08;
  localparam logic [7:0] TIME_OFS   = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // ==========================================================
  // control field positions
  localparam int CTRL_AGC_EN  = 0;
  localparam int CTRL_COMP_EN = 1;
  localparam int CTRL_HOLD_EN = 2;
  localparam int CTRL_SHDN    = 3;
  // ==========================================================
  // reset values
  localparam logic [31:0] CTRL_RST  = 32'h0000_0008;
  localparam logic [31:0] GAIN_RST  = 32'h0000_1e06;
  localparam logic [31:0] LEVEL_RST = 32'h0001_10c8;
  localparam logic [31:0] TIME_RST  = 32'h0010_2004;
  // ==========================================================
  // writable bits of each register; the rest store as zero
  localparam logic [31:0] CTRL_MASK  = 32'h0000_000f;
  localparam logic [31:0] GAIN_MASK  = 32'h0000_3fff;
  localparam logic [31:0] LEVEL_MASK = 32'h0003_ffff;
  localparam logic [31:0] TIME_MASK  = 32'h00ff_ffff;
  // ==========================================================
  // gain limits in whole dB (GAIN_MIN_HALF in 0.5 dB steps), reference level and timer top; gain itself is held in 0.5 dB steps
  localparam logic signed [7:0] FIX_MIN_COMP_DB = -8'sh1c;
  localparam logic signed [7:0] FIX_MIN_DB      = 8'sh00;
  localparam logic signed [7:0] FIX_MAX_DB      = 8'sh1e;
  localparam logic signed [7:0] GAIN_MIN_HALF   = -8'sh38;
  localparam logic signed [9:0] ROT_LVL         = 10'sh0c8;
  localparam logic [7:0]        ELAPSED_MAX     = 8'hff;
  // ==========================================================
  // timebase: one timer tick every TB_NS
  localparam int CLK_NS = 8;
  localparam int TB_NS  = 100000;
  localparam int TB_CYC = TB_NS / CLK_NS;
  localparam int TICK_CYC_MAX = 65535;
endpackage

// *** rtl/audio_agc_gain_stepper.sv ***
// automatic gain control engine with a classic wishbone register slave
// ==========================================================
// What this block does
// - gain moves by exactly one 0.5 dB step per permitted change.
// - step decisions use envelope, limiter, compression ratio, attack and release.
// - attack time is the least spacing between two gain decrements.
// - release time is the least spacing between two gain increments.
// - first increment after a decrement waits for the hold time.
// - envelope below noise gate freezes the gain.
// - fixed gain applies when control is off or in shutdown.
// - limiter level caps output; exceeding it reduces gain.
// - maximum gain is the top of the compression region; increments stop at it, fixed gain is not capped by it.
// - steady envelope leaves the gain unchanged.
// - first limiter overshoot with idle timers decrements at once, restarting timers.
// - no further decrement while the attack timer runs.
// - attack expired and still above limiter gives one more decrement.
// - release expired and below desired level gives one increment.
// - hold counts only if enabled and longer than release.
// - fixed gain spans -28..30 dB with compression, 0..30 dB without.
//
// Chosen here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
module audio_agc_gain_stepper
  import agc_pkg::*;
#(
  parameter int TICK_CYC = TB_CYC
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // envelope in, gain out
  input  wire logic [7:0]  env_i,
  output logic      [7:0]  gain_o,
  output logic             gain_up_o,
  output logic             gain_dn_o
);

  // the prescaler is 16 bits wide, so a longer tick period cannot be counted
  if (TICK_CYC < 1 || TICK_CYC > TICK_CYC_MAX) begin : g_tick_bad
    $error("TICK_CYC out of range");
  end

  // ==========================================================
  // register file
  logic [31:0] ctrl_q, gcfg_q, lcfg_q, tcfg_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        bus_req;
  logic        bus_wr;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = n[8*b +: 8];
    end
    return r;
  endfunction

  assign bus_req = cyc_i & stb_i & ~ack_q;
  assign bus_wr  = bus_req & we_i;
  assign ack_o   = ack_q;
  assign dat_o   = rdat_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) ack_q <= 1'b0;
    else ack_q <= bus_req;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      gcfg_q <= GAIN_RST;
      lcfg_q <= LEVEL_RST;
      tcfg_q <= TIME_RST;
    end else if (bus_wr) begin
      case (adr_i)
        CTRL_OFS:  ctrl_q <= merge(ctrl_q, dat_i, sel_i) & CTRL_MASK;
        GAIN_OFS:  gcfg_q <= merge(gcfg_q, dat_i, sel_i) & GAIN_MASK;
        LEVEL_OFS: lcfg_q <= merge(lcfg_q, dat_i, sel_i) & LEVEL_MASK;
        TIME_OFS:  tcfg_q <= merge(tcfg_q, dat_i, sel_i) & TIME_MASK;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // fields
  logic              agc_en, comp_en, hold_en, shdn, agc_act;
  logic signed [7:0] fix_db, fix_lo, fix_eff, fix2, max2;
  logic [7:0]        lim_lvl, gate_lvl, atk_t, rel_t, hold_t;
  logic [1:0]        ratio;

  assign agc_en   = ctrl_q[CTRL_AGC_EN];
  assign comp_en  = ctrl_q[CTRL_COMP_EN];
  assign hold_en  = ctrl_q[CTRL_HOLD_EN];
  assign shdn     = ctrl_q[CTRL_SHDN];
  assign agc_act  = agc_en & ~shdn;
  assign fix_db   = $signed(gcfg_q[7:0]);
  assign max2     = $signed({1'b0, gcfg_q[13:8], 1'b0});
  assign lim_lvl  = lcfg_q[7:0];
  assign gate_lvl = lcfg_q[15:8];
  assign ratio    = lcfg_q[17:16];
  assign atk_t    = tcfg_q[7:0];
  assign rel_t    = tcfg_q[15:8];
  assign hold_t   = tcfg_q[23:16];

  // fixed gain window depends on compression
  assign fix_lo  = comp_en ? FIX_MIN_COMP_DB : FIX_MIN_DB;
  assign fix_eff = (fix_db < fix_lo) ? fix_lo :
                   (fix_db > FIX_MAX_DB) ? FIX_MAX_DB : fix_db;
  assign fix2    = fix_eff <<< 1;

  // ==========================================================
  // timebase and elapsed-time counter
  logic [15:0] tb_q;
  logic        tick;
  logic [7:0]  elapsed_q;
  logic        last_dec_q;
  logic signed [7:0] gain_q;
  logic        step_up, step_dn;

  assign tick = (tb_q == 16'(TICK_CYC - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i) tb_q <= 16'h0000;
    else if (tick) tb_q <= 16'h0000;
    else tb_q <= tb_q + 16'h0001;
  end

  // saturating at its top means "no timer running"; idle after reset and disable
  always_ff @(posedge clk_i) begin
    if (rst_i) elapsed_q <= ELAPSED_MAX;
    else if (!agc_act) elapsed_q <= ELAPSED_MAX;
    else if (step_up || step_dn) elapsed_q <= 8'h00;
    else if (tick && elapsed_q != ELAPSED_MAX) elapsed_q <= elapsed_q + 8'h01;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) last_dec_q <= 1'b0;
    else if (step_dn) last_dec_q <= 1'b1;
    else if (step_up || !agc_act) last_dec_q <= 1'b0;
  end

  // ==========================================================
  // gain decision
  logic signed [9:0] out_lvl, diff, comp, desired, des_cap;
  logic              gate_on, dec_req, inc_req;
  logic [7:0]        inc_wait;

  assign out_lvl = $signed({2'b00, env_i}) + 10'(gain_q);
  assign diff    = (ROT_LVL > $signed({2'b00, env_i})) ? ROT_LVL - $signed({2'b00, env_i}) : 10'sh000;
  // only 1:1, 2:1, 4:1, 8:1 ratios: gain follows (1 - 1/ratio) of the level drop
  assign comp    = diff - (diff >>> ratio);
  assign desired = 10'(fix2) + comp;
  assign des_cap = (desired > 10'(max2)) ? 10'(max2) : desired;
  assign gate_on = env_i < gate_lvl;
  // limiter overshoot or gain above the compression curve both pull gain down
  assign dec_req = (out_lvl > $signed({2'b00, lim_lvl})) || (10'(gain_q) > des_cap);
  // a raise must not itself push the output past the limiter
  assign inc_req = (10'(gain_q) < des_cap) &&
                   (out_lvl < $signed({2'b00, lim_lvl}));
  assign inc_wait = (last_dec_q && hold_en && hold_t > rel_t) ? hold_t : rel_t;

  // steady envelope settles at des_cap, or lower where the limiter binds, and then neither request stands
  // the cycle after a step is skipped: with a zero threshold the timer is still 0 there,
  // so without this two steps could land back to back
  assign step_dn = agc_act && !gate_on && dec_req && elapsed_q >= atk_t &&
                   !gain_up_o && !gain_dn_o &&
                   gain_q > GAIN_MIN_HALF;
  assign step_up = agc_act && !gate_on && !dec_req && inc_req && elapsed_q >= inc_wait &&
                   !gain_up_o && !gain_dn_o &&
                   gain_q < max2;

  always_ff @(posedge clk_i) begin
    if (rst_i) gain_q <= 8'sh00;
    else if (!agc_act) gain_q <= fix2;
    else if (step_dn) gain_q <= gain_q - 8'sh01;
    else if (step_up) gain_q <= gain_q + 8'sh01;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_up_o <= 1'b0;
      gain_dn_o <= 1'b0;
    end else begin
      gain_up_o <= step_up;
      gain_dn_o <= step_dn;
    end
  end

  assign gain_o = gain_q;

  // ==========================================================
  // read data
  always_ff @(posedge clk_i) begin
    if (rst_i) rdat_q <= 32'h0000_0000;
    else if (bus_req && !we_i) begin
      case (adr_i)
        CTRL_OFS:   rdat_q <= ctrl_q;
        GAIN_OFS:   rdat_q <= gcfg_q;
        LEVEL_OFS:  rdat_q <= lcfg_q;
        TIME_OFS:   rdat_q <= tcfg_q;
        STATUS_OFS: rdat_q <= {13'h0000, gate_on, last_dec_q, agc_act, elapsed_q, gain_q};
        default:    rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_step;
    step_up || step_dn;
  endsequence

  sequence s_restart;
    ##1 (elapsed_q == 8'h00);
  endsequence

  gain_one_step_a: assert property (agc_act && $past(agc_act) && !$stable(gain_q) |->
    (gain_q - $past(gain_q) == 8'sh01) || ($past(gain_q) - gain_q == 8'sh01))
    else $error("gain moved by more than one step");

  timer_restart_a: assert property (s_step |-> s_restart)
    else $error("timers not restarted after gain change");

  attack_gap_a: assert property (step_dn |=> !step_dn)
    else $error("two decrements back to back");

  attack_wait_a: assert property (step_dn |-> elapsed_q >= atk_t)
    else $error("decrement before attack time");

  release_wait_a: assert property (step_up |-> elapsed_q >= rel_t)
    else $error("increment before release time");

  hold_wait_a: assert property (step_up && last_dec_q && hold_en && hold_t > rel_t |->
    elapsed_q >= hold_t)
    else $error("increment before hold time");

  gate_freeze_a: assert property (agc_act && gate_on ##1 agc_act |-> $stable(gain_q))
    else $error("gain moved under noise gate");

  fixed_apply_a: assert property (!agc_act |=> gain_q == $past(fix2))
    else $error("fixed gain not applied");

  max_cap_a: assert property (step_up |=> gain_q <= $past(max2))
    else $error("gain above maximum");

  limit_dec_a: assert property (step_dn |=> gain_dn_o && gain_q >= GAIN_MIN_HALF)
    else $error("decrement pulse or floor wrong");

  fixed_range_a: assert property (fix_eff >= fix_lo && fix_eff <= FIX_MAX_DB)
    else $error("fixed gain outside window");

  bus_ack_a: assert property (bus_req |=> ack_o ##1 !ack_o)
    else $error("ack not one cycle");

  // ==========================================================
  // step decisions are taken whenever the rules allow them, and only then
  sequence s_dn_applied;
    ##1 (gain_dn_o && !gain_up_o);
  endsequence

  sequence s_up_applied;
    ##1 (gain_up_o && !gain_dn_o);
  endsequence

  dec_pulse_a: assert property (step_dn |-> s_dn_applied)
    else $error("decrement pulse missing");

  inc_pulse_a: assert property (step_up |-> s_up_applied)
    else $error("increment pulse missing");

  dec_size_a: assert property (step_dn |=> gain_q == $past(gain_q) - 8'sh01)
    else $error("decrement not one step");

  inc_size_a: assert property (step_up |=> gain_q == $past(gain_q) + 8'sh01)
    else $error("increment not one step");

  pulse_excl_a: assert property (!(gain_up_o && gain_dn_o))
    else $error("both step pulses high");

  // idle timers let the first overshoot through at once
  first_dec_a: assert property (agc_act && !gate_on && dec_req && elapsed_q == ELAPSED_MAX &&
    gain_q > GAIN_MIN_HALF |-> step_dn)
    else $error("first overshoot not taken at once");

  attack_expire_a: assert property (agc_act && !gate_on && dec_req && elapsed_q >= atk_t &&
    !gain_up_o && !gain_dn_o && gain_q > GAIN_MIN_HALF |-> step_dn)
    else $error("decrement withheld after attack");

  release_expire_a: assert property (agc_act && !gate_on && !dec_req && inc_req &&
    elapsed_q >= inc_wait && !gain_up_o && !gain_dn_o && gain_q < max2 |-> step_up)
    else $error("increment withheld after release");

  release_plain_a: assert property (step_up && !(hold_en && hold_t > rel_t) |->
    elapsed_q >= rel_t)
    else $error("increment before release time");

  gate_block_a: assert property (gate_on |-> !step_up && !step_dn)
    else $error("step under noise gate");

  idle_block_a: assert property (!agc_act |-> !step_up && !step_dn)
    else $error("step while control inactive");

  steady_block_a: assert property (!dec_req && !inc_req |-> !step_up && !step_dn)
    else $error("step on steady envelope");

  limit_keep_a: assert property (step_up |-> out_lvl < $signed({2'b00, lim_lvl}))
    else $error("increment past limiter");

  curve_keep_a: assert property (step_up |-> 10'(gain_q) < des_cap)
    else $error("increment above compression curve");

  max_keep_a: assert property (agc_act && gain_up_o |-> gain_q <= max2)
    else $error("increment landed above maximum");

  floor_keep_a: assert property (agc_act |-> gain_q >= GAIN_MIN_HALF)
    else $error("gain below lowest step");

  fixed_plain_a: assert property (!comp_en |-> fix_eff >= FIX_MIN_DB)
    else $error("negative fixed gain without compression");

  // between ticks and steps the timer must not move
  timer_hold_a: assert property (agc_act && !tick && !step_up && !step_dn |=>
    elapsed_q == $past(elapsed_q))
    else $error("timer moved without a tick");

endmodule // audio_agc_gain_stepper

// *** test/wb_host.sv ***
// wishbone host model standing on the far side of the register slave
`timescale 1ns/1ps
module wb_host (
  // clock and answer
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  // request
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o  = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0;
  end
  // ==========================================================
  // one classic cycle, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o  <= w;
    adr_o <= a;
    sel_o <= 4'hf;
    dat_o <= d;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o  <= 1'b0;
    // released lines do not keep the old value
    adr_o <= ~a;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask
endmodule // wb_host

// *** test/audio_agc_gain_stepper_tb.sv ***
// self-checking bench for the gain stepper
`timescale 1ns/1ps
module audio_agc_gain_stepper_tb;
  import agc_pkg::*;
  localparam int T = 4;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  env_i = 8'h00;
  logic        cyc, stb, we, ack, up, dn;
  logic [7:0]  adr, gain;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [7:0]  exp_g[$];
  logic [31:0] exp_r[$];
  logic [7:0]  ofs[5] = '{CTRL_OFS, GAIN_OFS, LEVEL_OFS, TIME_OFS, 8'h14};
  logic [31:0] rst_v[5] = '{CTRL_RST, GAIN_RST, LEVEL_RST, TIME_RST, 32'h0};
  int          failures = 0, n_compared = 0, seed = 15648;
  int          cyc_n = 0, last = 0, lim, att, rel, hld;
  logic        prev_dn = 1'b0, started = 1'b0;
  // ==========================================================
  // clock, design and host
  always #4 clk_i = ~clk_i;
  audio_agc_gain_stepper #(.TICK_CYC(T)) audio_agc_gain_stepper_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .env_i(env_i),
    .gain_o(gain), .gain_up_o(up), .gain_dn_o(dn));
  wb_host wb_host_inst (
    .clk_i(clk_i), .ack_i(ack), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat));
  // ==========================================================
  // compare, verdict and bus helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic complete_run();
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_host_inst.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v);
    exp_r.push_back(v);
    wb_host_inst.xfer(1'b0, a, 32'h0);
  endtask
  // ==========================================================
  // monitor: every result takes the oldest note; a step nobody noted fails
  always @(posedge clk_i) begin
    cyc_n++;
    if (!rst_i && ack && !we) check(rdat, exp_r.size() ? exp_r.pop_front() : 32'hdead_beef);
    if (!rst_i && (up || dn)) begin
      lim = dn ? att : (prev_dn ? hld : rel);
      if (started) begin
        check(32'(cyc_n - last > (lim - 1) * T), 32'h1);
        check(32'(cyc_n - last <= lim * T + 2), 32'h1);
      end
      check(32'(gain), exp_g.size() ? 32'(exp_g.pop_front()) : 32'hffff);
      started = 1'b1;
      prev_dn = dn;
      last = cyc_n;
    end
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    complete_run();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(32'(gain), 32'd12);
    wr(8'h14, 32'hffff_ffff);
    foreach (ofs[i]) rd(ofs[i], rst_v[i]);
    // negative fixed gain only survives with compression on
    wr(GAIN_OFS, 32'h0000_1efb);
    repeat (3) @(posedge clk_i);
    check(32'(gain), 32'h0);
    wr(CTRL_OFS, 32'h0000_000a);
    repeat (3) @(posedge clk_i);
    check(32'(gain), 32'h0000_00f6);
    wr(GAIN_OFS, GAIN_RST);
    wr(LEVEL_OFS, 32'h0001_00c8);
    wr(TIME_OFS, 32'h0008_0302);
    att = 2;
    rel = 3;
    hld = 8;
    env_i <= 8'd220 + 8'($random(seed) & 31);
    for (int g = 11; g >= 9; g--) exp_g.push_back(8'(g));
    wr(CTRL_OFS, 32'h0000_0007);
    while (exp_g.size() > 0) @(posedge clk_i);
    // quiet input: hold first, then release steps up to the ceiling
    env_i <= 8'd80 + 8'($random(seed) & 15);
    for (int g = 10; g <= 60; g++) exp_g.push_back(8'(g));
    while (exp_g.size() > 0) @(posedge clk_i);
    repeat (200) @(posedge clk_i);
    wr(LEVEL_OFS, 32'h0001_ffc8);
    env_i <= 8'd250;
    repeat (200) @(posedge clk_i);
    check(32'(gain), 32'd60);
    wr(CTRL_OFS, 32'h0);
    repeat (3) @(posedge clk_i);
    check(32'(gain), 32'd12);
    rd(STATUS_OFS, 32'h0004_ff0c);
    complete_run();
  end
endmodule // audio_agc_gain_stepper_tb
